// >>> hw/hdtm_pkg.sv
// Package with register map, field layout and reset values of the HDLC timeslot mapping block
package hdtm_pkg;
   // Register offsets on the byte bus
   localparam logic [7:0] HDTM_OFF_RX_CTL = 8'hb8;
   localparam logic [7:0] HDTM_OFF_RX_SUPP = 8'hb9;
   localparam logic [7:0] HDTM_OFF_TX_CTL = 8'hba;
   localparam logic [7:0] HDTM_OFF_TX_SUPP = 8'hbb;
   localparam logic [7:0] HDTM_OFF_STATUS = 8'hbc;
   // Reset values
   localparam logic [7:0] HDTM_RST_CTL = 8'h00;
   localparam logic [7:0] HDTM_RST_SUPP = 8'h00;
   // Channel control field positions
   localparam int HDTM_POS_ENABLE = 7;
   localparam int HDTM_POS_SA_OR_CH = 6;
   localparam int HDTM_POS_MODE = 5;
   localparam int HDTM_POS_CHAN_HI = 4;
   localparam int HDTM_POS_CHAN_LO = 0;
   // Status field positions
   localparam int HDTM_POS_ST_RX = 0;
   localparam int HDTM_POS_ST_TX = 1;
   // Sa numbering: select bit 4 is Sa4 down to select bit 0 is Sa8
   localparam logic [3:0] HDTM_SA_LAST = 4'h8;
   localparam logic [3:0] HDTM_SA_FIRST = 4'h4;
   localparam int HDTM_CHAN_W = 5;
   localparam int HDTM_NUM_CHAN = 32;
endpackage

// >>> hw/hdtm_slot_select.sv
// Decides whether the current payload bit belongs to the HDLC path
`timescale 1ns/1ns
`default_nettype none
module hdtm_slot_select
   import hdtm_pkg::*;
#(
   parameter int NUM_CHAN = HDTM_NUM_CHAN
) (
   input wire logic enable_i, // Path enabled
   input wire logic sa_or_ch_i, // 0 Sa bits, 1 DS0 channels
   input wire logic mode_i, // 0 single channel, 1 block mask
   input wire logic [HDTM_CHAN_W-1:0] chan_i, // Single channel number
   input wire logic [NUM_CHAN-1:0] block_i, // Per-channel block mask
   input wire logic [7:0] suppress_i, // Per-bit suppress mask
   input wire logic [4:0] sa_en_i, // Sa4..Sa8 enables, bit 4 is Sa4
   input wire logic is_sa_i, // Current bit is an Sa bit
   input wire logic [3:0] sa_num_i, // Sa number 4..8
   input wire logic [HDTM_CHAN_W-1:0] ts_i, // Current timeslot
   input wire logic [2:0] bit_pos_i, // 0 is DS0 bit 1, 7 is DS0 bit 8
   output logic use_o // Bit is taken by HDLC
);
   logic sa_hit;
   logic chan_hit;
   logic [3:0] sa_idx;

   always_comb begin
      sa_idx = HDTM_SA_LAST - sa_num_i;
      sa_hit = 1'b0;
      if ((sa_num_i >= HDTM_SA_FIRST) && (sa_num_i <= HDTM_SA_LAST)) begin
         sa_hit = sa_en_i[sa_idx[2:0]];
      end
      // RULE_07 single or blocked
      chan_hit = mode_i ? block_i[ts_i] : (ts_i == chan_i);
   end

   // RULE_12 suppressed bits skipped
   always_comb begin
      if (!enable_i) begin
         use_o = 1'b0;
      end else if (is_sa_i) begin
         use_o = !sa_or_ch_i && sa_hit;
      end else begin
         use_o = sa_or_ch_i && chan_hit && !suppress_i[bit_pos_i];
      end
   end
endmodule
`default_nettype wire

// >>> hw/hdtm_top.sv
// HDLC timeslot mapping: register bank and bit selection for receive and transmit
// Operation
// RULE_01 - A receive suppress bit set to one keeps the matching receive DS0 bit (bit 7 is DS0 bit 8) out of HDLC.
// RULE_02 - A transmit suppress bit set to one keeps HDLC from inserting into the matching transmit DS0 bit.
// RULE_03 - With transmit enable at zero nothing is inserted; at one HDLC data goes to chosen Sa bits or channels.
// RULE_04 - The transmit Sa-or-channel select is ignored while transmit enable is zero.
// RULE_05 - With transmit select at zero HDLC uses Sa bits enabled by select bits 4 (Sa4) down to 0 (Sa8).
// RULE_06 - With transmit select at one HDLC uses DS0 channels chosen per the selection mode bit.
// RULE_07 - Transmit mode zero uses the single numbered channel; mode one uses all channels marked as blocked.
// RULE_08 - The five transmit channel bits form one binary number, bit 4 most significant.
// RULE_09 - Receive source zero takes Sa bits from the second receive control; one uses the channel control register.
// RULE_10 - Receive select zero routes enabled Sa bits (bit 4 Sa4 to bit 0 Sa8); one routes DS0 channels.
// RULE_11 - Receive mode zero chooses the single numbered channel; one chooses channels marked as blocked.
// RULE_12 - Suppressed bits are skipped, so the HDLC stream continues on the remaining bits in order.
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
module hdtm_top
   import hdtm_pkg::*;
#(
   parameter int NUM_CHAN = HDTM_NUM_CHAN
) (
   input wire logic core_clk_i, // 50 MHz clock
   input wire logic rst_n_i, // Synchronous reset, active low
   input wire logic [7:0] reg_addr_i, // Register byte address
   input wire logic [7:0] reg_wdata_i, // Write data
   input wire logic reg_we_i, // Write strobe
   input wire logic reg_re_i, // Read strobe
   output logic [7:0] reg_rdata_o, // Read data, cycle after strobe
   input wire logic [4:0] rx_control_two_sa_i, // Sa4..Sa8 enables from second receive control
   input wire logic [NUM_CHAN-1:0] rx_channel_block_regs_i, // Receive channel block mask
   input wire logic [NUM_CHAN-1:0] tx_channel_block_regs_i, // Transmit channel block mask
   input wire logic rx_strobe_i, // Receive payload bit present
   input wire logic rx_bit_i, // Receive payload bit value
   input wire logic [HDTM_CHAN_W-1:0] rx_ts_i, // Receive timeslot
   input wire logic [2:0] rx_bit_pos_i, // Receive DS0 bit, 0 is bit 1
   input wire logic rx_is_sa_i, // Receive bit is an Sa bit
   input wire logic [3:0] rx_sa_num_i, // Receive Sa number
   output logic hdlc_rx_valid_o, // Bit handed to HDLC receiver
   output logic hdlc_rx_bit_o, // Bit value for HDLC receiver
   input wire logic tx_strobe_i, // Transmit payload bit slot
   input wire logic tx_bit_i, // Framer's own transmit bit
   input wire logic [HDTM_CHAN_W-1:0] tx_ts_i, // Transmit timeslot
   input wire logic [2:0] tx_bit_pos_i, // Transmit DS0 bit, 0 is bit 1
   input wire logic tx_is_sa_i, // Transmit bit is an Sa bit
   input wire logic [3:0] tx_sa_num_i, // Transmit Sa number
   input wire logic hdlc_tx_bit_i, // Next bit from HDLC transmitter
   output logic hdlc_tx_take_o, // HDLC bit consumed this slot
   output logic tx_insert_o, // Output bit came from HDLC
   output logic tx_bit_o // Transmit bit after insertion
);
   logic [7:0] rx_ctl_r, rx_ctl_nxt;
   logic [7:0] rx_supp_r, rx_supp_nxt;
   logic [7:0] tx_ctl_r, tx_ctl_nxt;
   logic [7:0] tx_supp_r, tx_supp_nxt;
   logic [7:0] rdata_r, rdata_nxt;
   logic rx_valid_r, rx_valid_nxt;
   logic rx_bit_r, rx_bit_nxt;
   logic tx_ins_r, tx_ins_nxt;
   logic tx_bit_r, tx_bit_nxt;
   logic rx_seen_r, rx_seen_nxt;
   logic tx_seen_r, tx_seen_nxt;
   logic rx_use, tx_use;
   logic rx_sa_or_ch;
   logic [4:0] rx_sa_en;
   logic tx_enable;

   // Register writes
   always_comb begin
      rx_ctl_nxt = rx_ctl_r;
      rx_supp_nxt = rx_supp_r;
      tx_ctl_nxt = tx_ctl_r;
      tx_supp_nxt = tx_supp_r;
      if (reg_we_i) begin
         unique case (reg_addr_i)
            HDTM_OFF_RX_CTL: rx_ctl_nxt = reg_wdata_i;
            HDTM_OFF_RX_SUPP: rx_supp_nxt = reg_wdata_i;
            HDTM_OFF_TX_CTL: tx_ctl_nxt = reg_wdata_i;
            HDTM_OFF_TX_SUPP: tx_supp_nxt = reg_wdata_i;
            default: ;
         endcase
      end
   end

   // Read data stands only in the cycle after the strobe; unmapped reads give zero
   always_comb begin
      rdata_nxt = 8'h00;
      if (reg_re_i) begin
         unique case (reg_addr_i)
            HDTM_OFF_RX_CTL: rdata_nxt = rx_ctl_r;
            HDTM_OFF_RX_SUPP: rdata_nxt = rx_supp_r;
            HDTM_OFF_TX_CTL: rdata_nxt = tx_ctl_r;
            HDTM_OFF_TX_SUPP: rdata_nxt = tx_supp_r;
            HDTM_OFF_STATUS: begin
               rdata_nxt[HDTM_POS_ST_RX] = rx_seen_r;
               rdata_nxt[HDTM_POS_ST_TX] = tx_seen_r;
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         rx_ctl_r <= HDTM_RST_CTL;
         rx_supp_r <= HDTM_RST_SUPP;
         tx_ctl_r <= HDTM_RST_CTL;
         tx_supp_r <= HDTM_RST_SUPP;
         rdata_r <= 8'h00;
      end else begin
         rx_ctl_r <= rx_ctl_nxt;
         rx_supp_r <= rx_supp_nxt;
         tx_ctl_r <= tx_ctl_nxt;
         tx_supp_r <= tx_supp_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   assign reg_rdata_o = rdata_r;

   // RULE_09 source picks Sa field
   // RULE_10 Sa or channel routing
   always_comb begin
      if (rx_ctl_r[HDTM_POS_ENABLE]) begin
         rx_sa_or_ch = rx_ctl_r[HDTM_POS_SA_OR_CH];
         rx_sa_en = rx_ctl_r[4:0];
      end else begin
         rx_sa_or_ch = 1'b0;
         rx_sa_en = rx_control_two_sa_i;
      end
   end

   // RULE_11 receive channel choice
   // RULE_01 receive suppress mask
   hdtm_slot_select #(
      .NUM_CHAN(NUM_CHAN)
   ) u_rx_sel (
      .enable_i(1'b1),
      .sa_or_ch_i(rx_sa_or_ch),
      .mode_i(rx_ctl_r[HDTM_POS_MODE]),
      .chan_i(rx_ctl_r[HDTM_POS_CHAN_HI:HDTM_POS_CHAN_LO]),
      .block_i(rx_channel_block_regs_i),
      .suppress_i(rx_supp_r),
      .sa_en_i(rx_sa_en),
      .is_sa_i(rx_is_sa_i),
      .sa_num_i(rx_sa_num_i),
      .ts_i(rx_ts_i),
      .bit_pos_i(rx_bit_pos_i),
      .use_o(rx_use)
   );

   // RULE_04 select ignored when disabled
   assign tx_enable = tx_ctl_r[HDTM_POS_ENABLE];

   // RULE_05 Sa enables
   // RULE_06 channel routing
   // RULE_08 binary channel number
   // RULE_02 transmit suppress mask
   hdtm_slot_select #(
      .NUM_CHAN(NUM_CHAN)
   ) u_tx_sel (
      .enable_i(tx_enable),
      .sa_or_ch_i(tx_ctl_r[HDTM_POS_SA_OR_CH]),
      .mode_i(tx_ctl_r[HDTM_POS_MODE]),
      .chan_i(tx_ctl_r[HDTM_POS_CHAN_HI:HDTM_POS_CHAN_LO]),
      .block_i(tx_channel_block_regs_i),
      .suppress_i(tx_supp_r),
      .sa_en_i(tx_ctl_r[4:0]),
      .is_sa_i(tx_is_sa_i),
      .sa_num_i(tx_sa_num_i),
      .ts_i(tx_ts_i),
      .bit_pos_i(tx_bit_pos_i),
      .use_o(tx_use)
   );

   // Data path: one register stage on each direction
   always_comb begin
      rx_valid_nxt = rx_strobe_i && rx_use;
      rx_bit_nxt = rx_bit_r;
      if (rx_strobe_i && rx_use) begin
         rx_bit_nxt = rx_bit_i;
      end
      tx_ins_nxt = 1'b0;
      tx_bit_nxt = tx_bit_r;
      // RULE_03 insert only when enabled
      if (tx_strobe_i) begin
         tx_ins_nxt = tx_use;
         tx_bit_nxt = tx_use ? hdlc_tx_bit_i : tx_bit_i;
      end
      // Status shows whether the last payload bit went to or came from HDLC
      rx_seen_nxt = rx_strobe_i ? rx_use : rx_seen_r;
      tx_seen_nxt = tx_strobe_i ? tx_use : tx_seen_r;
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         rx_valid_r <= 1'b0;
         rx_bit_r <= 1'b0;
         tx_ins_r <= 1'b0;
         tx_bit_r <= 1'b0;
         rx_seen_r <= 1'b0;
         tx_seen_r <= 1'b0;
      end else begin
         rx_valid_r <= rx_valid_nxt;
         rx_bit_r <= rx_bit_nxt;
         tx_ins_r <= tx_ins_nxt;
         tx_bit_r <= tx_bit_nxt;
         rx_seen_r <= rx_seen_nxt;
         tx_seen_r <= tx_seen_nxt;
      end
   end

   assign hdlc_rx_valid_o = rx_valid_r;
   assign hdlc_rx_bit_o = rx_bit_r;
   assign tx_insert_o = tx_ins_r;
   assign tx_bit_o = tx_bit_r;
   // Combinational so the HDLC side can advance its shifter on the same edge
   assign hdlc_tx_take_o = tx_strobe_i && tx_use;

   // Checks
   sequence s_rx_ds0_bit;
      rx_strobe_i && !rx_is_sa_i && rx_ctl_r[HDTM_POS_ENABLE] && rx_ctl_r[HDTM_POS_SA_OR_CH];
   endsequence

   sequence s_tx_ds0_bit;
      tx_strobe_i && !tx_is_sa_i && tx_enable && tx_ctl_r[HDTM_POS_SA_OR_CH];
   endsequence

   a_rx_suppress_bit: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE_01
      s_rx_ds0_bit and rx_supp_r[rx_bit_pos_i] |=> !hdlc_rx_valid_o)
      else $error("suppressed receive bit reached HDLC");

   a_tx_suppress_bit: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE_02
      s_tx_ds0_bit and tx_supp_r[tx_bit_pos_i] |-> !hdlc_tx_take_o ##1 (!tx_insert_o && tx_bit_o == $past(tx_bit_i)))
      else $error("suppressed transmit bit was overwritten");

   a_tx_off_passes: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE_03
      tx_strobe_i && !tx_enable |=> !tx_insert_o && tx_bit_o == $past(tx_bit_i))
      else $error("HDLC data inserted while disabled");

   a_tx_off_no_take: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE_04
      !tx_enable |-> !hdlc_tx_take_o)
      else $error("HDLC bit taken while transmit disabled");

   a_tx_sa_insert: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE_05
      tx_strobe_i && tx_is_sa_i && tx_enable && !tx_ctl_r[HDTM_POS_SA_OR_CH] && tx_sa_num_i == 4'h4
      && tx_ctl_r[4] |=> tx_insert_o && tx_bit_o == $past(hdlc_tx_bit_i))
      else $error("enabled Sa4 not carrying HDLC data");

   a_tx_ch_no_sa: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE_06
      tx_strobe_i && tx_is_sa_i && tx_ctl_r[HDTM_POS_SA_OR_CH] |=> !tx_insert_o)
      else $error("Sa bit used in channel mode");

   a_tx_single_chan: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE_07
      s_tx_ds0_bit and !tx_ctl_r[HDTM_POS_MODE] && !tx_supp_r[tx_bit_pos_i]
      |-> hdlc_tx_take_o == (tx_ts_i == tx_ctl_r[4:0]))
      else $error("single channel selection wrong");

   a_tx_chan_number: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE_08
      s_tx_ds0_bit and !tx_ctl_r[HDTM_POS_MODE] && tx_supp_r == 8'h00 && tx_ts_i == {tx_ctl_r[4], 4'h0}
      && tx_ctl_r[3:0] == 4'h0 |=> tx_insert_o)
      else $error("channel number bit order wrong");

   a_rx_sa_source: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE_09
      rx_strobe_i && rx_is_sa_i && !rx_ctl_r[HDTM_POS_ENABLE] && rx_sa_num_i == 4'h8
      |=> hdlc_rx_valid_o == $past(rx_control_two_sa_i[0]))
      else $error("receive Sa8 source selection wrong");

   a_rx_ch_no_sa: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE_10
      rx_strobe_i && rx_is_sa_i && rx_ctl_r[HDTM_POS_ENABLE] && rx_ctl_r[HDTM_POS_SA_OR_CH] |=> !hdlc_rx_valid_o)
      else $error("receive Sa bit routed in channel mode");

   a_rx_block_chan: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE_11
      s_rx_ds0_bit and rx_ctl_r[HDTM_POS_MODE] && !rx_supp_r[rx_bit_pos_i]
      |=> hdlc_rx_valid_o == $past(rx_channel_block_regs_i[rx_ts_i])
      ##0 (!hdlc_rx_valid_o || hdlc_rx_bit_o == $past(rx_bit_i)))
      else $error("receive block mask selection wrong");

   a_rx_no_strobe: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE_12
      !rx_strobe_i |=> !hdlc_rx_valid_o ##0 $stable(hdlc_rx_bit_o))
      else $error("receive bit produced without payload strobe");

   a_tx_block_chan: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE_07
      s_tx_ds0_bit and tx_ctl_r[HDTM_POS_MODE] && !tx_supp_r[tx_bit_pos_i]
      |-> hdlc_tx_take_o == tx_channel_block_regs_i[tx_ts_i])
      else $error("transmit block mask selection wrong");

   a_tx_sa_no_ds0: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE_05
      tx_strobe_i && !tx_is_sa_i && tx_enable && !tx_ctl_r[HDTM_POS_SA_OR_CH] |=> !tx_insert_o)
      else $error("DS0 bit used in transmit Sa mode");

   a_rx_single_chan: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE_11
      s_rx_ds0_bit and !rx_ctl_r[HDTM_POS_MODE] && !rx_supp_r[rx_bit_pos_i]
      |=> hdlc_rx_valid_o == ($past(rx_ts_i) == $past(rx_ctl_r[4:0])))
      else $error("receive single channel selection wrong");

   a_rx_sa_select: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE_10
      rx_strobe_i && rx_is_sa_i && rx_ctl_r[HDTM_POS_ENABLE] && !rx_ctl_r[HDTM_POS_SA_OR_CH]
      && rx_sa_num_i == 4'h8 |=> hdlc_rx_valid_o == $past(rx_ctl_r[0]))
      else $error("receive Sa8 select wrong");

   a_rx_sa_no_ds0: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE_10
      rx_strobe_i && !rx_is_sa_i && !(rx_ctl_r[HDTM_POS_ENABLE] && rx_ctl_r[HDTM_POS_SA_OR_CH])
      |=> !hdlc_rx_valid_o)
      else $error("DS0 bit routed in receive Sa mode");

endmodule
`default_nettype wire

// >>> testbench/hdtm_framer_model.sv
// Framer payload stream and HDLC controller model facing the mapping block
`timescale 1ns/1ns
`default_nettype none
module hdtm_framer_model (
   input wire logic clk_i, // Clock
   input wire logic go_i, // Start one frame
   output logic busy_o, // Frame in progress
   output logic strobe_o, // Payload bit slot
   output logic bit_o, // Payload bit value
   output logic [4:0] ts_o, // Timeslot
   output logic [2:0] pos_o, // DS0 bit, 0 is bit 1
   output logic is_sa_o, // Sa bit marker
   output logic [3:0] sa_num_o, // Sa number
   output var logic hbit_o = 1'b0, // HDLC transmit bit
   input wire logic rx_valid_i, // Bit handed to HDLC receiver
   input wire logic rx_bit_i, // Its value
   input wire logic take_i, // HDLC bit consumed
   input wire logic insert_i, // Output bit came from HDLC
   input wire logic tx_bit_i, // Transmit bit after insertion
   output logic [8:0] rx_n_o, // Bits received by HDLC
   output logic [8:0] tx_n_o, // Bits taken from HDLC
   output logic [31:0] rx_ts_o, // Timeslots used on receive
   output logic [31:0] tx_ts_o, // Timeslots used on transmit
   output logic [7:0] rx_pos_o, // Bit places used on receive
   output logic [7:0] tx_pos_o, // Bit places used on transmit
   output logic [7:0] bad_o // Stream mismatches
);
   logic [8:0] cnt = 9'h100;
   logic tog = 1'b0;
   logic p_str, p_bit, p_take, p_hbit;
   logic [4:0] p_ts;
   logic [2:0] p_pos;
   wire logic rx_err;
   wire logic tx_err;
   // Bits go out MSB first, one every cycle, so back-to-back strobes are always exercised
   assign strobe_o = ~cnt[8];
   assign busy_o = strobe_o;
   assign ts_o = cnt[7:3];
   assign pos_o = ~cnt[2:0];
   // Idle line toggles so a stale value is never mistaken for data
   assign bit_o = cnt[8] ? tog : ^{cnt[0], cnt[3], cnt[6]};
   assign is_sa_o = strobe_o && ts_o == 5'h0 && pos_o <= 3'h4;
   assign sa_num_o = 4'h8 - {1'b0, pos_o};
   assign rx_err = rx_valid_i && (!p_str || rx_bit_i !== p_bit);
   assign tx_err = (take_i && !strobe_o) || (!p_str && insert_i)
      || (p_str && (insert_i !== p_take || tx_bit_i !== (p_take ? p_hbit : ~p_bit)));
   always_ff @(posedge clk_i) begin
      p_str <= strobe_o;
      p_bit <= bit_o;
      p_ts <= ts_o;
      p_pos <= pos_o;
      p_take <= take_i;
      p_hbit <= hbit_o;
      tog <= ~tog;
      if (take_i) hbit_o <= ~hbit_o;
      if (go_i) begin
         cnt <= 9'h000;
         rx_n_o <= 9'h000;
         tx_n_o <= 9'h000;
         rx_ts_o <= 32'h0000_0000;
         tx_ts_o <= 32'h0000_0000;
         rx_pos_o <= 8'h00;
         tx_pos_o <= 8'h00;
         bad_o <= 8'h00;
      end else begin
         if (!cnt[8]) cnt <= cnt + 9'h001;
         bad_o <= bad_o + {7'h00, rx_err} + {7'h00, tx_err};
         if (rx_valid_i) begin
            rx_n_o <= rx_n_o + 9'h001;
            rx_ts_o[p_ts] <= 1'b1;
            rx_pos_o[p_pos] <= 1'b1;
         end
         if (take_i) begin
            tx_n_o <= tx_n_o + 9'h001;
            tx_ts_o[ts_o] <= 1'b1;
            tx_pos_o[pos_o] <= 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// >>> testbench/hdtm_top_tb.sv
// Self-checking bench for the HDLC timeslot mapping block
`timescale 1ns/1ns
`default_nettype none
module hdtm_top_tb;
   import hdtm_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic we = 1'b0;
   logic re = 1'b0;
   logic go = 1'b0;
   logic [4:0] rx_sa = 5'h00;
   logic [31:0] rx_blk = 32'h0000_0000;
   logic [31:0] tx_blk = 32'h0000_0000;
   logic [7:0] rdata, rx_pos, tx_pos, bad;
   logic [31:0] rx_ts, tx_ts;
   logic [8:0] rx_n, tx_n;
   logic busy, str, fbit, is_sa, hbit, rvalid, rbit, take, ins, tbit;
   logic [4:0] ts;
   logic [2:0] pos;
   logic [3:0] sa_num;
   int errors = 0;
   int n_checks = 0;
   always #10 clk = ~clk;
   hdtm_top #(.NUM_CHAN(32)) hdtm_top_i (.core_clk_i(clk), .rst_n_i(rst_n), .reg_addr_i(addr),
      .reg_wdata_i(wdata), .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rdata), .rx_control_two_sa_i(rx_sa),
      .rx_channel_block_regs_i(rx_blk), .tx_channel_block_regs_i(tx_blk), .rx_strobe_i(str), .rx_bit_i(fbit),
      .rx_ts_i(ts), .rx_bit_pos_i(pos), .rx_is_sa_i(is_sa), .rx_sa_num_i(sa_num), .hdlc_rx_valid_o(rvalid),
      .hdlc_rx_bit_o(rbit), .tx_strobe_i(str), .tx_bit_i(~fbit), .tx_ts_i(ts), .tx_bit_pos_i(pos),
      .tx_is_sa_i(is_sa), .tx_sa_num_i(sa_num), .hdlc_tx_bit_i(hbit), .hdlc_tx_take_o(take),
      .tx_insert_o(ins), .tx_bit_o(tbit));
   hdtm_framer_model hdtm_framer_model_i (.clk_i(clk), .go_i(go), .busy_o(busy), .strobe_o(str),
      .bit_o(fbit), .ts_o(ts), .pos_o(pos), .is_sa_o(is_sa), .sa_num_o(sa_num), .hbit_o(hbit),
      .rx_valid_i(rvalid), .rx_bit_i(rbit), .take_i(take), .insert_i(ins), .tx_bit_i(tbit), .rx_n_o(rx_n),
      .tx_n_o(tx_n), .rx_ts_o(rx_ts), .tx_ts_o(tx_ts), .rx_pos_o(rx_pos), .tx_pos_o(tx_pos), .bad_o(bad));
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      we <= 1'b1;
      @(posedge clk);
      we <= 1'b0;
   endtask
   // Read data stands only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
      @(posedge clk);
      addr <= a;
      re <= 1'b1;
      @(posedge clk);
      re <= 1'b0;
      #1 chk(what, {24'h0, exp}, {24'h0, rdata});
   endtask
   task automatic frame(input logic rx, input logic [8:0] en, input logic [31:0] ets, input logic [7:0] epos);
      int i;
      @(posedge clk);
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      #1;
      for (i = 0; i < 400 && busy; i++) @(posedge clk);
      repeat (3) @(posedge clk);
      chk("stream bit order", 0, {24'h0, bad});
      chk("bit count", {23'h0, en}, rx ? {23'h0, rx_n} : {23'h0, tx_n});
      chk("timeslot map", ets, rx ? rx_ts : tx_ts);
      chk("bit place map", {24'h0, epos}, rx ? {24'h0, rx_pos} : {24'h0, tx_pos});
   endtask
   task automatic t_regs;
      rd(HDTM_OFF_RX_CTL, HDTM_RST_CTL, "rx ctl reset");
      rd(HDTM_OFF_RX_SUPP, HDTM_RST_SUPP, "rx supp reset");
      rd(HDTM_OFF_TX_CTL, HDTM_RST_CTL, "tx ctl reset");
      rd(HDTM_OFF_TX_SUPP, HDTM_RST_SUPP, "tx supp reset");
      wr(HDTM_OFF_RX_SUPP, 8'ha5);
      wr(8'hc0, 8'hff);
      rd(HDTM_OFF_RX_SUPP, 8'ha5, "rx supp");
      wr(HDTM_OFF_TX_SUPP, 8'h3c);
      rd(HDTM_OFF_TX_SUPP, 8'h3c, "tx supp");
      wr(HDTM_OFF_TX_CTL, 8'h5a);
      rd(HDTM_OFF_TX_CTL, 8'h5a, "tx ctl");
      rd(8'hc0, 8'h00, "unmapped read");
      $display("test regs done");
   endtask
   task automatic t_tx_off;
      wr(HDTM_OFF_TX_SUPP, 8'h00);
      wr(HDTM_OFF_TX_CTL, 8'h53);
      frame(1'b0, 9'h000, 32'h0000_0000, 8'h00);
      $display("test tx off done");
   endtask
   task automatic t_tx_sa;
      wr(HDTM_OFF_TX_CTL, 8'h98);
      frame(1'b0, 9'h002, 32'h0000_0001, 8'h18);
      $display("test tx sa done");
   endtask
   task automatic t_tx_ch;
      wr(HDTM_OFF_TX_SUPP, 8'h81);
      wr(HDTM_OFF_TX_CTL, 8'hd3);
      frame(1'b0, 9'h006, 32'h0008_0000, 8'h7e);
      wr(HDTM_OFF_TX_SUPP, 8'h00);
      wr(HDTM_OFF_TX_CTL, 8'hd0);
      frame(1'b0, 9'h008, 32'h0001_0000, 8'hff);
      $display("test tx channel done");
   endtask
   task automatic t_tx_blk;
      tx_blk <= 32'h8000_0006;
      wr(HDTM_OFF_TX_SUPP, 8'h0f);
      wr(HDTM_OFF_TX_CTL, 8'he0);
      frame(1'b0, 9'h00c, 32'h8000_0006, 8'hf0);
      $display("test tx block done");
   endtask
   task automatic t_rx_src;
      rx_sa <= 5'h07;
      wr(HDTM_OFF_RX_CTL, 8'h00);
      frame(1'b1, 9'h003, 32'h0000_0001, 8'h07);
      $display("test rx source done");
   endtask
   task automatic t_rx_sel;
      wr(HDTM_OFF_RX_CTL, 8'h81);
      frame(1'b1, 9'h001, 32'h0000_0001, 8'h01);
      $display("test rx sa select done");
   endtask
   task automatic t_rx_ch;
      wr(HDTM_OFF_RX_SUPP, 8'h80);
      wr(HDTM_OFF_RX_CTL, 8'hc5);
      frame(1'b1, 9'h007, 32'h0000_0020, 8'h7f);
      $display("test rx channel done");
   endtask
   task automatic t_rx_blk;
      rx_blk <= 32'h0000_0300;
      wr(HDTM_OFF_RX_SUPP, 8'h01);
      wr(HDTM_OFF_RX_CTL, 8'he0);
      frame(1'b1, 9'h00e, 32'h0000_0300, 8'hfe);
      $display("test rx block done");
   endtask
   initial begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      t_regs;
      t_tx_off;
      t_tx_sa;
      t_tx_ch;
      t_tx_blk;
      t_rx_src;
      t_rx_sel;
      t_rx_ch;
      t_rx_blk;
      report_and_stop;
   end
   // About two and a half times the cycles the tests need
   initial begin
      #120000;
      errors++;
      report_and_stop;
   end
endmodule
`default_nettype wire
